/* verilog/hlt_pkg.sv */
// Constants for the hardware-limit timer and timebase selector
package hlt_pkg;
  localparam logic [7:0] HLT_OFS_CTRL   = 8'h00; // control: sync, polarity, mode
  localparam logic [7:0] HLT_OFS_EN     = 8'h04; // bit 0 enable
  localparam logic [7:0] HLT_OFS_PERIOD = 8'h08; // period value
  localparam logic [7:0] HLT_OFS_COUNT  = 8'h0c; // count value (read only)
  localparam logic [7:0] HLT_OFS_PRESC  = 8'h10; // prescale select, low 2 bits
  localparam logic [7:0] HLT_OFS_SEL    = 8'h14; // timebase select
  localparam logic [7:0] HLT_OFS_STAT   = 8'h18; // running, gated
  localparam int HLT_BIT_PRESCALER_OUT_SYNC = 7;
  localparam int HLT_BIT_CLOCK_EDGE_POLARITY  = 6;
  localparam int HLT_BIT_ENABLE_SYNC_TO_CLOCK = 5;
  localparam logic [4:0] HLT_MODE_SW     = 5'h00;
  localparam logic [4:0] HLT_MODE_GATE_H = 5'h01; // halt while gate high
  localparam logic [4:0] HLT_MODE_GATE_L = 5'h02; // halt while gate low
  localparam logic [7:0] HLT_CTRL_RST   = 8'h00;
  localparam logic [7:0] HLT_PERIOD_RST = 8'hff;
  localparam logic [7:0] HLT_SEL_RST    = 8'h55;
  localparam logic [1:0] HLT_TB_FIRST  = 2'h1;
  localparam logic [1:0] HLT_TB_SECOND = 2'h2;
  localparam logic [1:0] HLT_TB_THIRD  = 2'h3;
  localparam int HLT_ENSYNC_CLKS = 2;
  localparam logic [1:0] HLT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] HLT_RESP_SLVERR = 2'h2;
endpackage

/* verilog/hlt_timer.sv */
// Gated period timer with timebase routing for capture/compare and PWM
//
// Contract
// - Hardware gate modes act like software mode plus external gate pause.
// - Mode 00001 halts while gate high; mode 00010 halts while low.
// - Gate pauses stretch PWM period, and high time when paused high.
// - With prescaler-sync set, count reads are never torn.
// - Polarity bit 1 counts falling input edges, 0 rising edges.
// - Enable-sync delays counting start by two timer input clocks.
// - Enable 1 starts, 0 halts with count kept.
// - PWM selectors: 11 third, 10 second, 01 first basic timer.
// - Capture selectors choose gated-counter and basic-timer pair; 00 reserved.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module hlt_timer
  import hlt_pkg::*;
#(
  parameter int CW = 8                     // counter width
)(
  input  wire logic          aclk,          // system clock, 100 MHz
  input  wire logic          aresetn,       // synchronous reset, active low
  input  wire logic [7:0]    s_axi_awaddr,  // write address
  input  wire logic          s_axi_awvalid, // write address valid
  output logic               s_axi_awready, // write address ready
  input  wire logic [31:0]   s_axi_wdata,   // write data
  input  wire logic [3:0]    s_axi_wstrb,   // write strobes
  input  wire logic          s_axi_wvalid,  // write data valid
  output logic               s_axi_wready,  // write data ready
  output logic [1:0]         s_axi_bresp,   // write response
  output logic               s_axi_bvalid,  // write response valid
  input  wire logic          s_axi_bready,  // write response ready
  input  wire logic [7:0]    s_axi_araddr,  // read address
  input  wire logic          s_axi_arvalid, // read address valid
  output logic               s_axi_arready, // read address ready
  output logic [31:0]        s_axi_rdata,   // read data
  output logic [1:0]         s_axi_rresp,   // read response
  output logic               s_axi_rvalid,  // read data valid
  input  wire logic          s_axi_rready,  // read data ready
  input  wire logic          timer_input_clock,     // timer clock pin
  input  wire logic          ext_gate_reset_signal, // external gate pin
  input  wire logic          sleep_mode,            // device asleep
  input  wire logic [CW-1:0] pwm_duty,              // duty for local PWM
  output logic [CW-1:0]      count_out,             // timebase count
  output logic               period_match,          // count equals period
  output logic               pwm_out,               // PWM from this timebase
  output logic [1:0]         pwm_unit_a_tb,         // 1..3 basic timer
  output logic [1:0]         pwm_unit_b_tb,         // 1..3 basic timer
  output logic [1:0]         capcomp_one_gated_tb,  // 1..3 gated counter
  output logic [1:0]         capcomp_one_pwm_tb,    // 1..3 basic timer
  output logic [1:0]         capcomp_two_gated_tb,  // 1..3 gated counter
  output logic [1:0]         capcomp_two_pwm_tb     // 1..3 basic timer
);
  if (CW < 1 || CW > 32)
    $error("hlt_timer: CW must be 1..32");

  logic [7:0]    ctrl_q;
  logic          en_q;
  logic [CW-1:0] period_q;
  logic [1:0]    presc_q;
  logic [7:0]    sel_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_shadow_q;
  logic [2:0]    clk_sync_q;
  logic [1:0]    gate_sync_q;
  logic          en_sync1_q, en_sync2_q;
  logic [2:0]    pre_cnt_q;
  logic          pre_tick_q;

  // Input pins: two flops; the clock edge stage compares flop two with a third flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_sync_q  <= 3'h0;
      gate_sync_q <= 2'h0;
    end
    else
    begin
      clk_sync_q  <= {clk_sync_q[1:0], timer_input_clock};
      gate_sync_q <= {gate_sync_q[0], ext_gate_reset_signal};
    end
  end

  wire clk_prev  = clk_sync_q[2];
  wire clk_now   = clk_sync_q[1];
  wire gate_lvl  = gate_sync_q[1];
  wire clock_edge_polarity      = ctrl_q[HLT_BIT_CLOCK_EDGE_POLARITY];
  wire prescaler_out_sync     = ctrl_q[HLT_BIT_PRESCALER_OUT_SYNC];
  wire enable_sync_to_clock     = ctrl_q[HLT_BIT_ENABLE_SYNC_TO_CLOCK];
  wire [4:0] mode = ctrl_q[4:0];
  wire edge_rise = clk_now & ~clk_prev;
  wire edge_fall = ~clk_now & clk_prev;
  wire tclk_edge = clock_edge_polarity ? edge_fall : edge_rise;

  // Enable passes two timer input clocks; cleared while off, never stale
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_q)
    begin
      en_sync1_q <= 1'b0;
      en_sync2_q <= 1'b0;
    end
    else if (tclk_edge)
    begin
      en_sync1_q <= en_q;
      en_sync2_q <= en_sync1_q;
    end
  end

  wire en_eff = enable_sync_to_clock ? (en_q & en_sync2_q) : en_q;
  wire gate_halt = (mode == HLT_MODE_GATE_H) ? gate_lvl :
                   (mode == HLT_MODE_GATE_L) ? ~gate_lvl : 1'b0;
  // Sleep stops the synchronised path, since the sync clock is gone then
  wire run = en_eff & ~gate_halt & ~(prescaler_out_sync & sleep_mode);

  // Prescaler 1:1, 1:2, 1:4, 1:8 counting selected edges
  wire [2:0] pre_mask = (3'h1 << presc_q) - 3'h1;
  wire pre_out = tclk_edge && ((pre_cnt_q & pre_mask) == pre_mask);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_q)
      pre_cnt_q <= 3'h0;
    else if (tclk_edge && run)
      pre_cnt_q <= pre_cnt_q + 3'h1;
  end

  // Resync stage adds one aclk of latency when prescaler-sync is set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_tick_q <= 1'b0;
    else
      pre_tick_q <= pre_out & run;
  end

  wire count_tick = prescaler_out_sync ? pre_tick_q & en_q : pre_out & run;
  wire match = (count_q == period_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= '0;
    else if (count_tick)
      count_q <= match ? '0 : count_q + 1'b1;
  end

  // Read shadow updated only between ticks, so a read never sees a half step
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_shadow_q <= '0;
    else if (!count_tick)
      count_shadow_q <= count_q;
  end

  // PWM from this timebase; paused counter holds level and stretches both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwm_out <= 1'b0;
    else
      pwm_out <= (count_q < pwm_duty);
  end

  assign count_out    = count_q;
  assign period_match = match;

  // Timebase routing; reserved code 00 drives 00 meaning no timebase
  assign pwm_unit_b_tb        = sel_q[7:6];
  assign pwm_unit_a_tb        = sel_q[5:4];
  assign capcomp_two_gated_tb = sel_q[3:2];
  assign capcomp_two_pwm_tb   = sel_q[3:2];
  assign capcomp_one_gated_tb = sel_q[1:0];
  assign capcomp_one_pwm_tb   = sel_q[1:0];

  // AXI4-Lite write: take address and data in either order
  logic          aw_hold_q, w_hold_q;
  logic [7:0]    aw_addr_q;
  logic [31:0]   w_data_q;
  logic          w_lane0_q;
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_hold_q | aw_take;
  wire w_have  = w_hold_q | w_take;
  wire [7:0]  wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
  wire        wr_lane = w_hold_q ? w_lane0_q : s_axi_wstrb[0];
  wire do_wr = aw_have & w_have & ~s_axi_bvalid;
  wire wr_ok = (wr_addr == HLT_OFS_CTRL) | (wr_addr == HLT_OFS_EN) |
               (wr_addr == HLT_OFS_PERIOD) | (wr_addr == HLT_OFS_PRESC) |
               (wr_addr == HLT_OFS_SEL) | (wr_addr == HLT_OFS_COUNT) |
               (wr_addr == HLT_OFS_STAT);
  wire wr_en = do_wr & wr_lane;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0;
      w_lane0_q    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= HLT_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_addr_q <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_q  <= s_axi_wdata;
        w_lane0_q <= s_axi_wstrb[0];
      end
      aw_hold_q <= do_wr ? 1'b0 : aw_have;
      w_hold_q  <= do_wr ? 1'b0 : w_have;
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? HLT_RESP_OKAY : HLT_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes, gated by the lane 0 strobe; only a period wider than 8 bits takes data above lane 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q   <= HLT_CTRL_RST;
      en_q     <= 1'b0;
      period_q <= CW'(HLT_PERIOD_RST);
      presc_q  <= 2'h0;
      sel_q    <= HLT_SEL_RST;
    end
    else if (wr_en)
    begin
      if (wr_addr == HLT_OFS_CTRL)
        ctrl_q <= wr_data[7:0];
      if (wr_addr == HLT_OFS_EN)
        en_q <= wr_data[0];
      if (wr_addr == HLT_OFS_PERIOD)
        period_q <= wr_data[CW-1:0];
      if (wr_addr == HLT_OFS_PRESC)
        presc_q <= wr_data[1:0];
      if (wr_addr == HLT_OFS_SEL)
        sel_q <= wr_data[7:0];
    end
  end

  // AXI4-Lite read, one cycle after address taken
  assign s_axi_arready = ~s_axi_rvalid;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [31:0] count_rd = 32'(prescaler_out_sync ? count_shadow_q : count_q);
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb
  begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    case (s_axi_araddr)
      HLT_OFS_CTRL:   rd_mux = {24'h0, ctrl_q};
      HLT_OFS_EN:     rd_mux = {31'h0, en_q};
      HLT_OFS_PERIOD: rd_mux = 32'(period_q);
      HLT_OFS_COUNT:  rd_mux = count_rd;
      HLT_OFS_PRESC:  rd_mux = {30'h0, presc_q};
      HLT_OFS_SEL:    rd_mux = {24'h0, sel_q};
      HLT_OFS_STAT:   rd_mux = {30'h0, gate_halt, run};
      default:        rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= HLT_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? HLT_RESP_OKAY : HLT_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks
  sequence s_wrap;
    count_tick && match;
  endsequence
  a_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wrap |=> count_q == '0) else $error("count did not wrap");
  a_step_one: assert property (@(posedge aclk) disable iff (!aresetn)
    count_tick && !match |=> count_q == $past(count_q) + 1'b1)
    else $error("count step not one");
  a_hold_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_q && !wr_en |=> $stable(count_q))
    else $error("count moved while disabled");
  a_gate_high: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == HLT_MODE_GATE_H && gate_lvl && !prescaler_out_sync |-> !count_tick)
    else $error("counted while gate high");
  a_gate_low: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == HLT_MODE_GATE_L && !gate_lvl && !prescaler_out_sync |-> !count_tick)
    else $error("counted while gate low");
  a_edge_pol: assert property (@(posedge aclk) disable iff (!aresetn)
    tclk_edge |-> clk_now == !clock_edge_polarity) else $error("wrong clock edge");
  a_ensync_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    enable_sync_to_clock && $rose(en_q) |-> !en_eff [*2])
    else $error("enable sync too early");
  a_sleep_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    prescaler_out_sync && sleep_mode |-> !run) else $error("ran in sleep");
  a_pwm_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) && $stable(count_q) && $stable(pwm_duty) ##1 1'b1
    |-> $stable(pwm_out)) else $error("pwm moved while paused");
  a_sel_route: assert property (@(posedge aclk) disable iff (!aresetn)
    capcomp_one_gated_tb == capcomp_one_pwm_tb &&
    pwm_unit_a_tb == sel_q[5:4]) else $error("route mismatch");
  a_shadow_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && prescaler_out_sync && s_axi_araddr == HLT_OFS_COUNT
    |=> s_axi_rdata == 32'($past(count_shadow_q)))
    else $error("torn count read");
endmodule
`default_nettype wire

/* testbench/hlt_far_end.sv */
// Far-side model: timer clock pin, gate pin and PWM duty source
`timescale 1ns/1ns
`default_nettype none
module hlt_far_end #(
  parameter int CW   = 8, // count width
  parameter int DUTY = 2  // duty compare value
)(
  input  wire logic     aclk, // system clock
  output logic          tclk, // timer input clock
  output logic          gate, // external gate level
  output logic [CW-1:0] duty  // PWM duty value
);
  initial
  begin
    tclk = 1'b0;
    gate = 1'b0;
    duty = CW'(DUTY);
  end
  // Duty reaches the registered PWM output one aclk later
  task automatic set_duty(input logic [CW-1:0] v);
    duty <= v;
    repeat (2) @(posedge aclk);
  endtask
  // Each level lasts 8 aclk, so the pin stays slower than aclk/4
  task automatic set_clk(input logic v);
    tclk <= v;
    repeat (8) @(posedge aclk);
  endtask
  // Gate settles through its synchroniser before the next pin edge
  task automatic set_gate(input logic v);
    gate <= v;
    repeat (4) @(posedge aclk);
  endtask
  // Clock stands still low between bursts
  task automatic tick(input int n);
    repeat (n)
    begin
      set_clk(1'b1);
      set_clk(1'b0);
    end
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the gated period timer
`timescale 1ns/1ns
`default_nettype none
module tb
  import hlt_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pwm_out;
  logic        sleep_mode, tclk, gate, pmatch;
  logic [7:0]  awaddr, araddr, count_out, duty;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r, pa, pb, c1g, c1p, c2g, c2p;
  int          n_errors, checks_done;

  hlt_timer #(.CW(8)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_input_clock(tclk),
    .ext_gate_reset_signal(gate), .sleep_mode(sleep_mode),
    .pwm_duty(duty), .count_out(count_out), .period_match(pmatch),
    .pwm_out(pwm_out), .pwm_unit_a_tb(pa), .pwm_unit_b_tb(pb),
    .capcomp_one_gated_tb(c1g), .capcomp_one_pwm_tb(c1p),
    .capcomp_two_gated_tb(c2g), .capcomp_two_pwm_tb(c2p));

  hlt_far_end #(.CW(8), .DUTY(2)) far_u (
    .aclk(aclk), .tclk(tclk), .gate(gate), .duty(duty));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cnt(input logic [7:0] e);
    chk("count", 32'(count_out), 32'(e));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!bvalid) @(posedge aclk);
    chk("bresp", 32'(bresp), 32'(HLT_RESP_OKAY));
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    v = rdata;
    e = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic t_reset();
    rd(HLT_OFS_SEL, d, r);
    chk("sel reg", d, 32'h55);
    chk("sel resp", 32'(r), 32'(HLT_RESP_OKAY));
    rd(HLT_OFS_PERIOD, d, r);
    chk("period reg", d, 32'hff);
    rd(8'h1c, d, r);
    chk("unmapped", 32'(r), 32'(HLT_RESP_SLVERR));
    chk("sel out", {24'h0, pa, pb, c1g, c1p}, 32'h55);
  endtask

  // The first write gives the two PWM fields, and the two capture fields, different codes, so a swapped pair shows up
  task automatic t_select();
    wr(HLT_OFS_SEL, 32'he7);
    chk("pwm sel", {28'h0, pb, pa}, 32'he);
    chk("ccp sel", {24'h0, c2g, c2p, c1g, c1p}, 32'h5f);
    wr(HLT_OFS_SEL, 32'h7a);
    chk("pwm sel", {28'h0, pb, pa}, 32'h7);
    chk("ccp sel", {24'h0, c2g, c2p, c1g, c1p}, 32'haa);
    wr(HLT_OFS_SEL, 32'h55);
    chk("pwm sel", {28'h0, pb, pa}, 32'h5);
    chk("ccp sel", {24'h0, c2g, c2p, c1g, c1p}, 32'h55);
  endtask

  task automatic t_count();
    wr(HLT_OFS_PERIOD, 32'h3);
    wr(HLT_OFS_EN, 32'h1);
    for (int i = 1; i <= 6; i++)
    begin
      far_u.tick(1);
      cnt(8'(i % 4));
      chk("match", 32'(pmatch), 32'(i % 4 == 3));
    end
    wr(HLT_OFS_EN, 32'h0);
    far_u.tick(2);
    cnt(8'h2);
  endtask

  task automatic t_polarity();
    wr(HLT_OFS_CTRL, 32'h40);
    wr(HLT_OFS_EN, 32'h1);
    far_u.set_clk(1'b1);
    cnt(8'h2);
    far_u.set_clk(1'b0);
    cnt(8'h3);
    // Disable first: an edge select flip while running can fake a tick
    wr(HLT_OFS_EN, 32'h0);
  endtask

  task automatic t_gate();
    wr(HLT_OFS_CTRL, 32'(HLT_MODE_GATE_H));
    wr(HLT_OFS_EN, 32'h1);
    far_u.tick(2);
    cnt(8'h1);
    far_u.set_gate(1'b1);
    rd(HLT_OFS_STAT, d, r);
    chk("status", d, 32'h2);
    far_u.tick(3);
    cnt(8'h1);
    chk("pwm held", 32'(pwm_out), 32'h1);
    far_u.set_gate(1'b0);
    far_u.tick(1);
    cnt(8'h2);
    chk("pwm low", 32'(pwm_out), 32'h0);
    far_u.set_duty(8'h3);
    chk("pwm duty", 32'(pwm_out), 32'h1);
    wr(HLT_OFS_EN, 32'h0);
    wr(HLT_OFS_CTRL, 32'(HLT_MODE_GATE_L));
    wr(HLT_OFS_EN, 32'h1);
    far_u.tick(2);
    cnt(8'h2);
    far_u.set_gate(1'b1);
    far_u.tick(1);
    cnt(8'h3);
  endtask

  task automatic t_prescaler_out_sync();
    wr(HLT_OFS_EN, 32'h0);
    wr(HLT_OFS_CTRL, 32'h80);
    wr(HLT_OFS_EN, 32'h1);
    far_u.tick(1);
    rd(HLT_OFS_COUNT, d, r);
    chk("count reg", d, 32'h0);
    sleep_mode <= 1'b1;
    far_u.tick(2);
    cnt(8'h0);
    sleep_mode <= 1'b0;
    far_u.tick(1);
    cnt(8'h1);
  endtask

  // Two selected edges pass the enable; the third one counts
  task automatic t_ensync();
    wr(HLT_OFS_EN, 32'h0);
    wr(HLT_OFS_CTRL, 32'h20);
    wr(HLT_OFS_EN, 32'h1);
    far_u.tick(2);
    cnt(8'h1);
    far_u.tick(1);
    cnt(8'h2);
  endtask

  task automatic t_presc();
    wr(HLT_OFS_EN, 32'h0);
    wr(HLT_OFS_CTRL, 32'(HLT_MODE_SW));
    wr(HLT_OFS_PRESC, 32'h1);
    wr(HLT_OFS_EN, 32'h1);
    rd(HLT_OFS_STAT, d, r);
    chk("status", d, 32'h1);
    far_u.tick(1);
    cnt(8'h2);
    far_u.tick(1);
    cnt(8'h3);
    far_u.tick(2);
    cnt(8'h0);
    // Lane 0 off: the write is answered but lands nowhere
    wstrb <= 4'h0;
    wr(HLT_OFS_PERIOD, 32'h7);
    wstrb <= 4'hf;
    rd(HLT_OFS_PERIOD, d, r);
    chk("period kept", d, 32'h3);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, sleep_mode} = 49'h0;
    wstrb = 4'hf;
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_select();
    t_count();
    t_polarity();
    t_gate();
    t_prescaler_out_sync();
    t_ensync();
    t_presc();
    give_verdict();
  end

  // Whole run needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
